// *** rtc_pkg.sv ***
package rtc_pkg;

  // Chain geometry
  localparam int PRE_W   = 16;
  localparam int S0_W    = 10;
  localparam int S1_W    = 6;
  localparam int S2_W    = 6;
  localparam int S3_W    = 10;
  localparam int NUM_STG = 5;
  localparam int SRC_N   = 4;

  // Terminal counts of the fixed dividers and the stages
  localparam logic [4:0]  DIV32_LAST = 5'h1f;
  localparam logic [2:0]  DIV8_LAST  = 3'h7;
  localparam logic [15:0] PRE_LAST   = 16'hffff;
  localparam logic [15:0] S0_LAST    = 16'h03ff;
  localparam logic [15:0] S1_LAST    = 16'h003f;
  localparam logic [15:0] S2_LAST    = 16'h003f;
  localparam logic [15:0] S3_LAST    = 16'h03ff;

  // Interrupt flag positions
  localparam int FLG_PRE = 0;
  localparam int FLG_S0  = 1;
  localparam int FLG_S1  = 2;
  localparam int FLG_S2  = 3;
  localparam int FLG_S3  = 4;

  // Clock source choices
  typedef enum logic [1:0] {
    SRC_INT0 = 2'b00,
    SRC_INT1 = 2'b01,
    SRC_EXT0 = 2'b10,
    SRC_EXT1 = 2'b11
  } rtc_src_t;

  // Whole 48-bit chain, prescaler on top, lowest time stage at the bottom
  typedef struct packed {
    logic [PRE_W-1:0] prescale;
    logic [S3_W-1:0]  s3;
    logic [S2_W-1:0]  s2;
    logic [S1_W-1:0]  s1;
    logic [S0_W-1:0]  s0;
  } rtc_count_t;

  typedef struct packed {
    logic               src_prev;
    logic [4:0]         div32;
    logic [2:0]         div8;
    rtc_count_t         cnt;
    logic [NUM_STG-1:0] flags;
    logic               irq;
  } rtc_state_t;

  localparam rtc_state_t STATE_RESET = '0;

endpackage : rtc_pkg

// *** rtc_divider_chain_timer.sv ***
// Summary of operation
// R1: Chain is clocked by edges of a configurable internal or external source.
// R2: Divide-by-32 and divide-by-8 prescalers, each switched in or bypassed.
// R3: A 16-bit prescale timer follows, reloading its start value on wrap.
// R4: 32-bit count of 10, 6, 6, 10 bit stages, read as two words.
// R5: Every stage, prescale timer included, counts upward only.
// R6: Each stage raises its own request flag to signal ticks and alarms.
// R7: Stage requests merge into one shared request line.
// R8: Only the power reset initialises the clock's registers.
// R9: Prescale timer and time count together form one 48-bit counter.
// R10: Stage overflow advances the next stage and reloads its own value.
// R11: Request set on overflow, gated by a per-stage enable before merging.
module rtc_divider_chain_timer
  import rtc_pkg::*;
(
  // Clock and power reset
  input  wire logic               sys_clk,
  input  wire logic               rst_n,
  // Clock source
  input  wire logic [SRC_N-1:0]   src_clk,
  input  wire rtc_src_t           src_sel,
  input  wire logic               run_en,
  // Prescaler selection
  input  wire logic               div32_en,
  input  wire logic               div8_en,
  // Reload values and direct load
  input  wire rtc_count_t         reload,
  input  wire logic               count_load,
  input  wire rtc_count_t         count_load_value,
  // Requests
  input  wire logic [NUM_STG-1:0] irq_en,
  input  wire logic [NUM_STG-1:0] irq_clear,
  output logic [NUM_STG-1:0]      irq_flags,
  output logic                    irq_req,
  // Count readout
  output logic [PRE_W-1:0]        prescale_timer,
  output logic [15:0]             count_high_word,
  output logic [15:0]             count_low_word,
  output logic [47:0]             long_count
);

  rtc_state_t st;
  rtc_state_t next_st;

  // One up-counting stage: returns {overflow, next value}
  function automatic logic [16:0] stage_step(
    input logic [15:0] cnt,
    input logic [15:0] last,
    input logic [15:0] rld,
    input logic        tick
  );
    logic [16:0] res;
    res = {1'b0, cnt};
    if (tick) begin
      if (cnt == last) begin
        res = {1'b1, rld}; // R10
      end else begin
        res = {1'b0, cnt + 16'h0001}; // R5
      end
    end
    return res;
  endfunction : stage_step

  // One fixed divider: returns {tick out, next count}
  function automatic logic [8:0] div_step(
    input logic [7:0] cnt,
    input logic [7:0] last,
    input logic       enable,
    input logic       tick
  );
    logic [8:0] res;
    res = {1'b0, cnt};
    if (!enable) begin
      // Bypassed: the tick passes straight on, the counter rests at zero
      res = {tick, 8'h00}; // R2
    end else if (tick) begin
      if (cnt == last) begin
        res = {1'b1, 8'h00}; // R2
      end else begin
        res = {1'b0, cnt + 8'h01}; // R5
      end
    end
    return res;
  endfunction : div_step

  // Sticky flags; set wins over clear so a tick meeting a clear is kept
  function automatic logic [NUM_STG-1:0] flag_step(
    input logic [NUM_STG-1:0] flags,
    input logic [NUM_STG-1:0] clr,
    input logic [NUM_STG-1:0] set
  );
    return (flags & ~clr) | set; // R6
  endfunction : flag_step

  // Only enabled flags reach the shared request line
  function automatic logic merge_req(
    input logic [NUM_STG-1:0] flags,
    input logic [NUM_STG-1:0] en
  );
    return |(flags & en); // R11
  endfunction : merge_req

  logic               src_level;
  logic               src_edge;
  logic [8:0]         r_div32;
  logic [8:0]         r_div8;
  logic               tick_div32;
  logic               tick_div8;
  logic               tick_s0;
  logic               tick_s1;
  logic               tick_s2;
  logic               tick_s3;
  logic [16:0]        r_pre;
  logic [16:0]        r_s0;
  logic [16:0]        r_s1;
  logic [16:0]        r_s2;
  logic [16:0]        r_s3;
  logic [NUM_STG-1:0] ovf;
  logic [NUM_STG-1:0] flags_new;

  always_comb begin
    next_st = st;

    // Sources are taken as synchronous; a rising edge is one count event
    src_level        = src_clk[src_sel]; // R1
    next_st.src_prev = src_level;
    // Level is tracked while stopped, so a restart adds no false edge
    src_edge         = src_level & ~st.src_prev & run_en; // R1

    // Divide by 32, fed by source edges
    r_div32       = div_step({3'h0, st.div32},
                             {3'h0, DIV32_LAST},
                             div32_en,
                             src_edge); // R2
    tick_div32    = r_div32[8];
    next_st.div32 = r_div32[4:0]; // R2

    // Divide by 8, fed by the first divider
    r_div8        = div_step({5'h00, st.div8},
                             {5'h00, DIV8_LAST},
                             div8_en,
                             tick_div32); // R2
    tick_div8     = r_div8[8];
    next_st.div8  = r_div8[2:0]; // R2

    // Prescale timer heads the counting chain
    r_pre = stage_step(st.cnt.prescale,
                       PRE_LAST,
                       reload.prescale,
                       tick_div8); // R3
    tick_s0 = r_pre[16]; // R10

    // Full ripple in one cycle; long carry path traded for simple timing
    r_s0  = stage_step({6'h00, st.cnt.s0},
                       S0_LAST,
                       {6'h00, reload.s0},
                       tick_s0); // R4 R10
    tick_s1 = r_s0[16]; // R10
    r_s1  = stage_step({10'h000, st.cnt.s1},
                       S1_LAST,
                       {10'h000, reload.s1},
                       tick_s1); // R4 R10
    tick_s2 = r_s1[16]; // R10
    r_s2  = stage_step({10'h000, st.cnt.s2},
                       S2_LAST,
                       {10'h000, reload.s2},
                       tick_s2); // R4 R10
    tick_s3 = r_s2[16]; // R10
    r_s3  = stage_step({6'h00, st.cnt.s3},
                       S3_LAST,
                       {6'h00, reload.s3},
                       tick_s3); // R4 R10

    // Top stage overflow only raises its flag; the top stage reloads its own value

    ovf = '0;
    if (count_load) begin
      // A direct load wins over counting; that cycle's tick is dropped
      next_st.cnt = count_load_value; // R9
    end else begin
      next_st.cnt.prescale = r_pre[PRE_W-1:0];
      next_st.cnt.s0       = r_s0[S0_W-1:0];
      next_st.cnt.s1       = r_s1[S1_W-1:0];
      next_st.cnt.s2       = r_s2[S2_W-1:0];
      next_st.cnt.s3       = r_s3[S3_W-1:0];
      ovf[FLG_PRE] = r_pre[16]; // R6 R11
      ovf[FLG_S0]  = r_s0[16]; // R6 R11
      ovf[FLG_S1]  = r_s1[16]; // R6 R11
      ovf[FLG_S2]  = r_s2[16]; // R6 R11
      ovf[FLG_S3]  = r_s3[16]; // R6 R11
    end

    // Request follows the new flags, so it rises in the overflow cycle
    flags_new     = flag_step(st.flags, irq_clear, ovf); // R6
    next_st.flags = flags_new;
    next_st.irq   = merge_req(flags_new, irq_en); // R7 R11
  end

  // rst_n is the power reset; other system resets must not reach it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= STATE_RESET; // R8
    end else begin
      st <= next_st;
    end
  end

  assign irq_flags       = st.flags;
  assign irq_req         = st.irq; // R7
  assign prescale_timer  = st.cnt.prescale;
  assign count_high_word = {st.cnt.s3, st.cnt.s2}; // R4
  assign count_low_word  = {st.cnt.s1, st.cnt.s0}; // R4
  assign long_count      = st.cnt; // R9

endmodule : rtc_divider_chain_timer

// *** rtc_chain_props.sv ***
module rtc_chain_props
  import rtc_pkg::*;
(
  // Clock, reset and watched ports
  input wire logic               sys_clk,
  input wire logic               rst_n,
  input wire rtc_count_t         reload,
  input wire logic               count_load,
  input wire rtc_count_t         count_load_value,
  input wire logic [NUM_STG-1:0] irq_en,
  input wire logic [NUM_STG-1:0] irq_clear,
  input wire logic [NUM_STG-1:0] irq_flags,
  input wire logic               irq_req,
  input wire logic [47:0]        long_count
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  load_takes_a: assert property (count_load |=>
    long_count == $past(count_load_value)) else $error("load lost");
  req_merge_a: assert property (
    irq_req == |(irq_flags & $past(irq_en))) else $error("bad request");
  flag_sticky_a: assert property (
    (~$past(irq_clear) & $past(irq_flags) & ~irq_flags) == '0)
    else $error("flag dropped");
  // Direct load and wrap excluded, so any move of the prescaler other than a step is a slip
  pre_step_a: assert property (!$past(count_load)
    && $changed(long_count[47:32]) && $past(long_count[47:32]) != 16'hffff
    |-> long_count[47:32] == $past(long_count[47:32]) + 16'h0001)
    else $error("prescaler step");
  pre_wrap_a: assert property ($rose(irq_flags[0]) |->
    $past(long_count[47:32]) == 16'hffff
    && long_count[47:32] == $past(reload.prescale)) else $error("pre wrap");
  low_wrap_a: assert property ($rose(irq_flags[1]) |->
    $past(long_count[9:0]) == 10'h3ff) else $error("s0 early flag");
  low_reload_a: assert property ($rose(irq_flags[1]) |->
    long_count[9:0] == $past(reload.s0)) else $error("s0 reload");
  top_wrap_a: assert property ($rose(irq_flags[4]) |->
    $past(long_count[31:22]) == 10'h3ff) else $error("s3 early flag");
endmodule : rtc_chain_props

bind rtc_divider_chain_timer rtc_chain_props u_props (.sys_clk, .rst_n,
  .reload, .count_load, .count_load_value, .irq_en, .irq_clear, .irq_flags,
  .irq_req, .long_count);

// *** rtc_divider_chain_timer_tb_top.sv ***
module rtc_divider_chain_timer_tb_top
  import rtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic               sys_clk, rst_n, run_en, div32_en, div8_en;
  logic               count_load, irq_req;
  logic [SRC_N-1:0]   src_clk;
  rtc_src_t           src_sel;
  rtc_count_t         reload, count_load_value;
  logic [NUM_STG-1:0] irq_en, irq_clear, irq_flags;
  logic [15:0]        prescale_timer, count_high_word, count_low_word;
  logic [47:0]        long_count;
  int                 fails, tests_run;

  rtc_divider_chain_timer dut (.*);

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Source held low a full cycle so every pulse is one clean edge
  task automatic edges(input int n, input logic [3:0] m);
    repeat (n) begin
      @(negedge sys_clk) src_clk = m;
      @(negedge sys_clk) src_clk = 4'h0;
    end
  endtask : edges

  task automatic ld(input rtc_count_t v);
    @(negedge sys_clk) count_load = 1'b1;
    count_load_value = v;
    @(negedge sys_clk) count_load = 1'b0;
  endtask : ld

  task automatic t_ripple();
    reload = 48'h1234_5678_9abc;
    irq_en = 5'h05;
    ld(48'hffff_ffff_ffff);
    edges(1, 4'h1);
    chk(long_count, reload);
    chk(irq_flags, 5'h1f);
    chk(irq_req, 1'b1);
    chk(count_high_word, reload[31:16]);
    chk(count_low_word, reload[15:0]);
    chk(prescale_timer, reload[47:32]);
  endtask : t_ripple

  task automatic t_gate();
    @(negedge sys_clk) irq_en = 5'h00;
    @(negedge sys_clk) chk(irq_req, 1'b0);
    irq_en = 5'h10;
    @(negedge sys_clk) chk(irq_req, 1'b1);
    irq_clear = 5'h1f;
    @(negedge sys_clk) irq_clear = 5'h00;
    chk(irq_flags, 5'h00);
    chk(irq_req, 1'b0);
  endtask : t_gate

  task automatic t_div();
    ld('0);
    div32_en = 1'b1;
    edges(31, 4'h1);
    chk(prescale_timer, 16'h0000);
    edges(1, 4'h1);
    chk(prescale_timer, 16'h0001);
    div8_en = 1'b1;
    ld('0);
    edges(255, 4'h1);
    chk(prescale_timer, 16'h0000);
    edges(1, 4'h1);
    chk(prescale_timer, 16'h0001);
    div32_en = 1'b0;
    div8_en = 1'b0;
  endtask : t_div

  task automatic t_src();
    run_en = 1'b0;
    ld('0);
    edges(1, 4'hf);
    chk(prescale_timer, 16'h0000);
    run_en = 1'b1;
    for (int s = 0; s < SRC_N; s++) begin
      src_sel = rtc_src_t'(s);
      edges(1, ~(4'h1 << s));
      edges(1, 4'h1 << s);
      chk(prescale_timer, 16'(s + 1));
    end
  endtask : t_src

  task automatic finish_test();
    if (fails == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  initial begin
    {rst_n, src_clk, src_sel, div32_en, div8_en, count_load} = '0;
    {reload, count_load_value, irq_en, irq_clear} = '0;
    run_en = 1'b1;
    repeat (3) @(negedge sys_clk);
    rst_n = 1'b1;
    t_ripple();
    t_gate();
    t_div();
    t_src();
    finish_test();
  end
endmodule : rtc_divider_chain_timer_tb_top
